/* rtl/rgen_pkg.sv */
// constants, field layouts and carrier types of the power-good reset generator
// assumes a 100 MHz core clock and a simple runtime-register access port
// Functional notes
// - power-good output only pulled low, never high
// - three supply trip monitors always act as sources
// - control bit 1 adds over-temperature trip source
// - control bit 0 set removes watchdog as source
// - strap picks pulse width, 200 or 500 msec
// - strap sampled when pci or main reset deasserts
// - control register at 1dh, resets 00h, 7:3 reserved
// - host reaches watchdog enable; enabled watchdog drives output
// - kick bit is control bit 2, cleared by main reset
// - watchdog counter cleared while main reset asserted
// - counter starts after main reset and kick rise
// - each kick rise reloads 1.6 seconds, counts down
// - expiry without kick gives a 100 msec pulse
// - after expiry watchdog idles until next kick rise
// - kick falling edge leaves the counter running
package rgen_pkg;

  // register map
  localparam logic [7:0] RGEN_CTRL_OFFSET = 8'h1d;
  localparam logic [7:0] RGEN_CTRL_RESET = 8'h00;
  localparam int RGEN_CTRL_W = 3; // implemented low bits, rest read zero

  // control register field positions
  localparam int RGEN_BIT_WDOG_DIS = 0;
  localparam int RGEN_BIT_THERM_EN = 1;
  localparam int RGEN_BIT_KICK = 2;

  // clock and documented times
  localparam int RGEN_CLK_KHZ = 100000;
  localparam int RGEN_WDOG_TIME_MS = 1600; // 1.6 seconds
  localparam int RGEN_PW_SHORT_MS = 200;
  localparam int RGEN_PW_LONG_MS = 500;
  localparam int RGEN_WDOG_PULSE_MS = 100;

  // derived cycle counts
  localparam int RGEN_WDOG_CYCLES = RGEN_WDOG_TIME_MS * RGEN_CLK_KHZ;
  localparam int RGEN_PW_SHORT_CYCLES = RGEN_PW_SHORT_MS * RGEN_CLK_KHZ;
  localparam int RGEN_PW_LONG_CYCLES = RGEN_PW_LONG_MS * RGEN_CLK_KHZ;
  localparam int RGEN_WDOG_PULSE_CYCLES = RGEN_WDOG_PULSE_MS * RGEN_CLK_KHZ;
  localparam int RGEN_CNT_W = 28;

  // synchroniser bundle layout and its value during reset
  localparam int RGEN_SYNC_W = 7;
  localparam logic [6:0] RGEN_SYNC_RESET = 7'h09; // therm_n, strap high

  // runtime-register access request
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rgen_reg_req_s;

  // asynchronous pin inputs as one bundle
  typedef struct packed {
    logic v33_trip;
    logic v33_stby_trip;
    logic v5_trip;
    logic over_temp_trip_n;
    logic main_supply_por_n;
    logic pci_reset_n;
    logic pulse_width_strap;
  } rgen_pins_s;

endpackage

/* rtl/rgen_timer.sv */
// reloadable down-counter used for the watchdog and the pulse stretchers
// assumes clear and load come from logic on the same clock
`timescale 1ns/1ps
module rgen_timer
  import rgen_pkg::*;
#(
  parameter int W = RGEN_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  // state
  output logic running,
  output logic expired,
  output logic [W-1:0] count
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic expired_reg;
  wire last_tick = (count_reg == W'(1));

  // clear beats load, load beats the countdown
  assign count_next = clear ? '0 : load ? load_value :
                      (count_reg != '0) ? count_reg - W'(1) : count_reg;

  // counter and one-cycle expiry pulse; reaching zero is the cleared state
  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      expired_reg <= last_tick && !load && !clear;
    end
  end

  assign running = (count_reg != '0);
  assign expired = expired_reg;
  assign count = count_reg;

endmodule

/* rtl/rgen_top.sv */
// power-good reset generator: fault sources, reset watchdog, pulse stretcher
// assumes pin inputs are asynchronous and the register port is on clk
`timescale 1ns/1ps
module rgen_top
  import rgen_pkg::*;
#(
  parameter int WDOG_CYCLES = RGEN_WDOG_CYCLES,
  parameter int PW_SHORT_CYCLES = RGEN_PW_SHORT_CYCLES,
  parameter int PW_LONG_CYCLES = RGEN_PW_LONG_CYCLES,
  parameter int WDOG_PULSE_CYCLES = RGEN_WDOG_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous pins
  input wire rgen_pins_s pins,
  // runtime register port
  input wire rgen_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // open-drain power-good pin
  output logic power_good_out_o,
  output logic power_good_out_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [RGEN_SYNC_W-1:0] sync1_reg; // first stage, read only by sync2_reg
  logic [RGEN_SYNC_W-1:0] sync2_reg;
  rgen_pins_s pin_s;

  // two flops before anything looks at a pin
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= RGEN_SYNC_RESET;
      sync2_reg <= RGEN_SYNC_RESET;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  assign pin_s = sync2_reg;

  // delayed copies for release-edge detection
  logic por_n_d_reg;
  logic pci_n_d_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      por_n_d_reg <= 1'b0;
      pci_n_d_reg <= 1'b0;
    end else begin
      por_n_d_reg <= pin_s.main_supply_por_n;
      pci_n_d_reg <= pin_s.pci_reset_n;
    end
  end
  wire por_active = !pin_s.main_supply_por_n;
  wire por_release = pin_s.main_supply_por_n && !por_n_d_reg;
  wire pci_release = pin_s.pci_reset_n && !pci_n_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  logic strap_reg; // 1 selects the short width
  logic strap_next;
  assign strap_next = (por_release || pci_release) ? pin_s.pulse_width_strap : strap_reg;

  // taken after the release, never under the reset itself
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_reg <= 1'b1;
    end else begin
      strap_reg <= strap_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [RGEN_CTRL_W-1:0] ctrl_reg;
  logic [RGEN_CTRL_W-1:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  wire ctrl_hit = (reg_req.addr == RGEN_CTRL_OFFSET);
  wire ctrl_wr = reg_req.wr && ctrl_hit;
  wire [RGEN_CTRL_W-1:0] ctrl_wr_val = reg_req.wdata[RGEN_CTRL_W-1:0];

  // kick rise: a write taking bit 2 from 0 to 1 outside main reset
  wire kick_rise = ctrl_wr && ctrl_wr_val[RGEN_BIT_KICK] && !ctrl_reg[RGEN_BIT_KICK]
                   && !por_active;

  // main reset wins over a host write on the kick bit
  assign ctrl_next = {ctrl_wr ? ctrl_wr_val[RGEN_BIT_KICK] && !por_active :
                        ctrl_reg[RGEN_BIT_KICK] && !por_active,
                      ctrl_wr ? ctrl_wr_val[RGEN_BIT_THERM_EN:0] : ctrl_reg[RGEN_BIT_THERM_EN:0]};

  // reserved bits and unmapped offsets read as zero
  assign rdata_next = (reg_req.rd && ctrl_hit) ? {5'h00, ctrl_reg} : 8'h00;

  // register and registered read data
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= RGEN_CTRL_RESET[RGEN_CTRL_W-1:0];
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset watchdog and its timeout pulse

  logic wdog_running;
  logic wdog_expired;
  logic [RGEN_CNT_W-1:0] wdog_count;
  logic wpulse_running;
  logic [RGEN_CNT_W-1:0] wpulse_count;

  // held cleared in main reset, reloaded on kick rise only; a falling
  // kick is simply not an input here, so the count runs on
  rgen_timer #(.W(RGEN_CNT_W)) u_wdog (
    .clk(clk),
    .reset(reset),
    .clear(por_active),
    .load(kick_rise),
    .load_value(RGEN_CNT_W'(WDOG_CYCLES)),
    .running(wdog_running),
    .expired(wdog_expired),
    .count(wdog_count)
  );

  // expiry starts the timeout pulse; the watchdog then idles at zero
  rgen_timer #(.W(RGEN_CNT_W)) u_wpulse (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .load(wdog_expired),
    .load_value(RGEN_CNT_W'(WDOG_PULSE_CYCLES)),
    .running(wpulse_running),
    .expired(),
    .count(wpulse_count)
  );
  wire wdog_timeout_n = !wpulse_running;

  ////////////////////////////////////////////////////////////////////////////
  // fault sources and output stretcher

  wire supply_fault = pin_s.v33_trip || pin_s.v33_stby_trip || pin_s.v5_trip || por_active;
  wire therm_fault = ctrl_reg[RGEN_BIT_THERM_EN] && !pin_s.over_temp_trip_n;
  wire wdog_fault = !ctrl_reg[RGEN_BIT_WDOG_DIS] && !wdog_timeout_n;
  wire any_fault = supply_fault || therm_fault || wdog_fault;

  logic stretch_running;
  logic [RGEN_CNT_W-1:0] stretch_count;
  // width follows the strap value being taken this cycle, so a release edge counts at once
  wire [RGEN_CNT_W-1:0] width_cycles = strap_next ? RGEN_CNT_W'(PW_SHORT_CYCLES) :
                                                    RGEN_CNT_W'(PW_LONG_CYCLES);
  // the last fault cycle comes one edge before its release is seen; restart a running
  // pulse on that release so it takes the freshly sampled width
  wire stretch_load = any_fault || (stretch_running && (por_release || pci_release));

  // reloaded every fault cycle, so the width counts from the last one
  rgen_timer #(.W(RGEN_CNT_W)) u_stretch (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .load(stretch_load),
    .load_value(width_cycles),
    .running(stretch_running),
    .expired(),
    .count(stretch_count)
  );

  // drive low while faulted or stretching; the data level is always low
  logic pg_oe_n_reg;
  logic pg_data_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      pg_oe_n_reg <= 1'b0;
      pg_data_reg <= 1'b0;
    end else begin
      pg_oe_n_reg <= !(any_fault || stretch_running);
      pg_data_reg <= 1'b0;
    end
  end
  assign power_good_out_oe_n = pg_oe_n_reg;
  assign power_good_out_o = pg_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  od_never_high_a: assert property (power_good_out_o == 1'b0)
    else $error("power-good driven high");
  supply_source_a: assert property (supply_fault |=> !power_good_out_oe_n)
    else $error("supply fault did not pull power-good low");
  therm_source_a: assert property (therm_fault |=> !power_good_out_oe_n ##1 !power_good_out_oe_n)
    else $error("thermal trip not honoured");
  wdog_gate_a: assert property (wpulse_running && !ctrl_reg[0] |=> !power_good_out_oe_n)
    else $error("enabled watchdog pulse did not pull low");
  width_load_a: assert property (any_fault |=> stretch_count == (strap_reg ? RGEN_CNT_W'(PW_SHORT_CYCLES) :
                                    RGEN_CNT_W'(PW_LONG_CYCLES)))
    else $error("stretch width does not follow strap");
  strap_sample_a: assert property (por_release |=> strap_reg == $past(pin_s.pulse_width_strap))
    else $error("strap not taken at release");
  read_back_a: assert property (reg_req.rd && ctrl_hit |=> reg_rdata == {5'h00, $past(ctrl_reg)})
    else $error("control read-back wrong");
  enable_write_a: assert property (ctrl_wr |=> ctrl_reg[0] == $past(reg_req.wdata[0]))
    else $error("watchdog enable not written");
  kick_por_a: assert property (por_active |=> ctrl_reg[RGEN_BIT_KICK] == 1'b0)
    else $error("kick bit survives main reset");
  wdog_hold_a: assert property (por_active |=> !wdog_running)
    else $error("watchdog runs in main reset");
  kick_load_a: assert property (kick_rise |=> wdog_count == RGEN_CNT_W'(WDOG_CYCLES))
    else $error("kick did not reload watchdog");
  kick_fall_a: assert property (ctrl_wr && !reg_req.wdata[2] && wdog_count > RGEN_CNT_W'(2) && !por_active
                                 |=> wdog_running)
    else $error("falling kick disturbed watchdog");
  expire_pulse_a: assert property (wdog_expired |=> wpulse_count == RGEN_CNT_W'(WDOG_PULSE_CYCLES))
    else $error("timeout pulse not started");
  idle_after_a: assert property (wdog_expired && !kick_rise |=> !wdog_running && wdog_count == '0)
    else $error("watchdog restarted without kick");
  release_a: assert property (!any_fault && !stretch_running |=> power_good_out_oe_n)
    else $error("power-good held without cause");

  wdog_expire_c: cover property (wdog_expired);
  pg_release_c: cover property (!power_good_out_oe_n ##1 power_good_out_oe_n);
  kick_c: cover property (kick_rise ##[1:8] kick_rise);

endmodule

/* tb/rgen_board_model.sv */
// board side of the power-good net: pull-up and reset consumers
// assumes the design splits its open-drain pin into data and low-active enable
`timescale 1ns/1ps
module rgen_board_model (
  // pin pair from the design
  input wire logic pin_o,
  input wire logic pin_oe_n,
  // level the consumers see
  output logic power_good
);
  // a released net floats up to the pull-up, never holds its last value
  assign power_good = pin_oe_n ? 1'b1 : pin_o;
endmodule

/* tb/testbench.sv */
// self-checking bench of the power-good reset generator
// assumes shortened counts and a pulled-up power-good net
`timescale 1ns/1ps
module testbench;
  import rgen_pkg::*;
  // short counts keep the run brief
  localparam int WD = 200;
  localparam int PWS = 40;
  localparam int PWL = 100;
  localparam int WP = 20;
  ////////////////////////////////////////
  // stimulus, observation, bookkeeping
  logic clk = 1'b0;
  logic reset = 1'b1;
  rgen_pins_s pins;
  rgen_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic pg_o;
  logic pg_oe_n;
  logic pg;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;

  rgen_top #(.WDOG_CYCLES(WD), .PW_SHORT_CYCLES(PWS), .PW_LONG_CYCLES(PWL), .WDOG_PULSE_CYCLES(WP)) uut (
    .clk(clk), .reset(reset), .pins(pins), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .power_good_out_o(pg_o), .power_good_out_oe_n(pg_oe_n));
  rgen_board_model board (.pin_o(pg_o), .pin_oe_n(pg_oe_n), .power_good(pg));

  // 100 mhz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // hang guard, well above the expected few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      report_and_stop;
    end
  end

  // a driven pin must only ever be pulled low
  always @(negedge clk) begin
    if (!reset && pg_oe_n === 1'b0 && pg_o !== 1'b0) begin
      bad_count++;
      $display("ERROR power_good_out_o expected 0 seen %b", pg_o);
    end
  end
  ////////////////////////////////////////
  // helpers
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // one-cycle strobes, entered and left at a falling edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(negedge clk);
    reg_req.wr = 1'b0;
    // one idle cycle so a following call never re-raises the strobe in this step
    @(negedge clk);
  endtask

  // read data stands for the cycle after the taking edge
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(negedge clk);
    reg_req.rd = 1'b0;
    check(name, exp, reg_rdata);
    // one idle cycle so a following call never re-raises the strobe in this step
    @(negedge clk);
  endtask

  // cycles until the net reaches lvl, bounded by max
  task automatic wait_lvl(input logic lvl, input int max, output int k);
    k = 0;
    while (pg !== lvl && k < max) begin
      @(negedge clk);
      k++;
    end
  endtask

  // short fault on one source, then time the stretched release
  task automatic fault_width(input int sel, input int w, input string name);
    int k;
    case (sel)
      0: pins.v33_trip = 1'b1;
      1: pins.v33_stby_trip = 1'b1;
      2: pins.v5_trip = 1'b1;
      default: pins.over_temp_trip_n = 1'b0;
    endcase
    repeat (6) @(negedge clk);
    check(name, 8'h00, 8'(pg));
    pins.v33_trip = 1'b0;
    pins.v33_stby_trip = 1'b0;
    pins.v5_trip = 1'b0;
    pins.over_temp_trip_n = 1'b1;
    wait_lvl(1'b1, w + 20, k);
    check_rng(name, w, w + 8, k);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    pins = 7'h0f; // no faults, resets released, strap high
    reg_req = '0;
    repeat (2) @(negedge clk);
    check("oe_n in reset", 8'h00, 8'(pg_oe_n));
    reset = 1'b0;
    wait_lvl(1'b1, 100, n);
    check_rng("release width", PWS, PWS + 8, n);
    reg_rd(8'h1d, 8'h00, "ctrl reset");
    reg_wr(8'h1d, 8'hff);
    reg_rd(8'h1d, 8'h07, "ctrl rw");
    reg_rd(8'h3c, 8'h00, "unmapped read");
    reg_wr(8'h1c, 8'h00);
    reg_rd(8'h1d, 8'h07, "ctrl kept");
    wait_lvl(1'b0, 300, n);
    check_rng("wdog disabled", 300, 300, n);
    fault_width(3, PWS, "therm on");
    reg_wr(8'h1d, 8'h01);
    pins.over_temp_trip_n = 1'b0;
    repeat (10) @(negedge clk);
    check("therm off", 8'h01, 8'(pg));
    pins.over_temp_trip_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      fault_width(i, PWS, "supply trip");
    end
    // long width strap taken at the pci reset release
    pins.pulse_width_strap = 1'b0;
    pins.pci_reset_n = 1'b0;
    repeat (5) @(negedge clk);
    pins.pci_reset_n = 1'b1;
    repeat (5) @(negedge clk);
    fault_width(0, PWL, "long width");
    // watchdog expiry, host kicks as 0 then 1
    reg_wr(8'h1d, 8'h00);
    reg_wr(8'h1d, 8'h04);
    wait_lvl(1'b0, WD - 8, n);
    check_rng("wdog quiet", WD - 8, WD - 8, n);
    wait_lvl(1'b0, 16, n);
    check_rng("wdog fire", 0, 15, n);
    wait_lvl(1'b1, 300, n);
    check_rng("wdog pulse", WP + PWL, WP + PWL + 8, n);
    wait_lvl(1'b0, 400, n);
    check_rng("wdog idle", 400, 400, n);
    // a falling kick must not restart the count
    reg_wr(8'h1d, 8'h00);
    reg_wr(8'h1d, 8'h04);
    repeat (100) @(negedge clk);
    reg_wr(8'h1d, 8'h00);
    wait_lvl(1'b0, WD - 110, n);
    check_rng("kick fall quiet", WD - 110, WD - 110, n);
    wait_lvl(1'b0, 16, n);
    check_rng("kick fall fire", 0, 15, n);
    wait_lvl(1'b1, 300, n);
    // a full toggle before expiry reloads the interval
    reg_wr(8'h1d, 8'h04);
    repeat (150) @(negedge clk);
    reg_wr(8'h1d, 8'h00);
    reg_wr(8'h1d, 8'h04);
    wait_lvl(1'b0, WD - 8, n);
    check_rng("kick reload", WD - 8, WD - 8, n);
    wait_lvl(1'b0, 16, n);
    wait_lvl(1'b1, 300, n);
    // main power-on reset: kick refused, counter cleared, strap resampled
    reg_wr(8'h1d, 8'h04);
    pins.pulse_width_strap = 1'b1;
    pins.main_supply_por_n = 1'b0;
    repeat (6) @(negedge clk);
    check("por fault", 8'h00, 8'(pg));
    reg_wr(8'h1d, 8'h04);
    reg_rd(8'h1d, 8'h00, "kick refused");
    pins.main_supply_por_n = 1'b1;
    wait_lvl(1'b1, 100, n);
    check_rng("por width", PWS, PWS + 8, n);
    wait_lvl(1'b0, 400, n);
    check_rng("por idle", 400, 400, n);
    reg_wr(8'h1d, 8'h04);
    wait_lvl(1'b0, WD - 8, n);
    check_rng("por kick quiet", WD - 8, WD - 8, n);
    wait_lvl(1'b0, 16, n);
    check_rng("por kick fire", 0, 15, n);
    report_and_stop;
  end
endmodule
